// >>> logic/iod_params.svh
// Address map constants and field positions for the I/O space decoder
`ifndef IOD_PARAMS_SVH
`define IOD_PARAMS_SVH
`define IOD_DATA_OFFSET 8'h20
`define IOD_BIT_LIMIT 8'h1f
`define IOD_SHORT_LIMIT 8'h3f
`define IOD_EXT_BASE 8'h60
`define IOD_LOW_TOP 8'h5f
`define IOD_CTRL_CYCLES 1
`define IOD_FLAG_REG_INDEX 8'h15
`define IOD_RESET_BYTE 8'h00
`endif

// >>> logic/iod_pkg.sv
// Types shared by the I/O space decoder
package iod_pkg;
	typedef enum logic [3:0] {
		IOD_OP_NONE,
		IOD_OP_IN,
		IOD_OP_OUT,
		IOD_OP_BIT_SET,
		IOD_OP_BIT_CLR,
		IOD_OP_SKIP_ONE,
		IOD_OP_SKIP_ZERO,
		IOD_OP_DS_READ,
		IOD_OP_DS_WRITE,
		IOD_OP_IDLE,
		IOD_OP_SLEEP,
		IOD_OP_WDOG_CLR,
		IOD_OP_BREAK
	} iod_op_t;
	typedef enum logic [1:0] {
		IOD_STATE_IDLE,
		IOD_STATE_RMW
	} iod_state_t;
endpackage

// >>> logic/iod_mem.sv
// Register storage for the data-space I/O window, registered read data
`timescale 1ns/1ps
`include "iod_params.svh"
module iod_mem #(
	parameter int DEPTH = 256,
	parameter int AW = 8
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [AW-1:0] raddr,
	output logic [7:0] rdata,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [7:0] wdata
);
	logic [7:0] mem [DEPTH];
	logic [7:0] next_rdata;

	always_comb begin
		next_rdata = mem[raddr];
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rdata <= `IOD_RESET_BYTE;
		end else begin
			rdata <= next_rdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end
endmodule

// >>> logic/iod_decoder.sv
// I/O space access decoder between core execute stage and register file
// ----------------------------------------
// Summary of operation
// ----------------------------------------
`timescale 1ns/1ps
`include "iod_params.svh"
module iod_decoder #(
	parameter logic [255:0] RESERVED_MAP = 256'h0,
	parameter logic [255:0] W1C_MAP = 256'h0
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic op_valid,
	input wire iod_pkg::iod_op_t op_code,
	input wire logic [7:0] op_addr,
	input wire logic [2:0] op_bit,
	input wire logic [7:0] op_wdata,
	input wire logic [7:0] flag_set,
	input wire logic [7:0] flag_set_addr,
	output logic op_done,
	output logic op_error,
	output logic [7:0] op_rdata,
	output logic skip_next,
	output logic sleep_req,
	output logic watchdog_clear,
	output logic debug_break
);
	// ----------------------------------------
	// Address helpers
	// ----------------------------------------
	function automatic logic [7:0] io_to_data(input logic [7:0] a);
		io_to_data = 8'(a + `IOD_DATA_OFFSET);
	endfunction

	function automatic logic addr_legal(input iod_pkg::iod_op_t op, input logic [7:0] a);
		case (op)
			iod_pkg::IOD_OP_BIT_SET, iod_pkg::IOD_OP_BIT_CLR,
			iod_pkg::IOD_OP_SKIP_ONE, iod_pkg::IOD_OP_SKIP_ZERO:
				addr_legal = (a <= `IOD_BIT_LIMIT);
			iod_pkg::IOD_OP_IN, iod_pkg::IOD_OP_OUT:
				addr_legal = (a <= `IOD_SHORT_LIMIT);
			iod_pkg::IOD_OP_DS_READ, iod_pkg::IOD_OP_DS_WRITE:
				addr_legal = (a >= `IOD_DATA_OFFSET);
			default:
				addr_legal = 1'b1;
		endcase
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	iod_pkg::iod_state_t state, next_state;
	logic [7:0] hold_daddr, next_hold_daddr;
	logic hold_set, next_hold_set;
	logic [2:0] hold_bit, next_hold_bit;
	logic next_op_done, next_op_error, next_skip_next;
	logic next_sleep_req, next_watchdog_clear, next_debug_break;
	logic [7:0] next_op_rdata;
	logic [7:0] mem_raddr, mem_waddr, mem_wdata, mem_rdata;
	logic mem_we;
	logic [7:0] daddr;
	logic legal, rsvd;
	logic read_pend, next_read_pend;
	logic [7:0] merged;
	logic [7:0] flag_daddr, flag_reg, next_flag_reg, cur_rdata;
	logic [7:0] final_wdata;
	logic final_we;

	iod_mem #(
		.DEPTH(256),
		.AW(8)
	) u_mem (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.raddr(mem_raddr),
		.rdata(mem_rdata),
		.we(final_we),
		.waddr(mem_waddr),
		.wdata(final_wdata)
	);

	always_comb begin
		case (op_code)
			iod_pkg::IOD_OP_DS_READ, iod_pkg::IOD_OP_DS_WRITE: daddr = op_addr;
			default: daddr = io_to_data(op_addr);
		endcase
		legal = addr_legal(op_code, op_addr);
		rsvd = RESERVED_MAP[daddr];
		flag_daddr = io_to_data(flag_set_addr);
		// The hardware flag register lives in flops so events land in any cycle
		cur_rdata = (hold_daddr == flag_daddr) ? flag_reg : mem_rdata;
	end

	always_comb begin
		next_state = state;
		next_hold_daddr = hold_daddr;
		next_hold_set = hold_set;
		next_hold_bit = hold_bit;
		next_read_pend = 1'b0;
		next_op_done = 1'b0;
		next_op_error = 1'b0;
		next_op_rdata = op_rdata;
		next_skip_next = 1'b0;
		next_sleep_req = 1'b0;
		next_watchdog_clear = 1'b0;
		next_debug_break = 1'b0;
		mem_raddr = daddr;
		mem_we = 1'b0;
		mem_waddr = daddr;
		mem_wdata = op_wdata;
		merged = 8'h00;
		case (state)
			iod_pkg::IOD_STATE_RMW: begin
				// Whole register written back: flags read as one get cleared, except the bit that a bit clear names
				merged = cur_rdata;
				merged[hold_bit] = hold_set;
				mem_we = 1'b1;
				mem_waddr = hold_daddr;
				mem_wdata = W1C_MAP[hold_daddr] ? 8'(cur_rdata & ~merged) : merged;
				next_op_done = 1'b1;
				next_state = iod_pkg::IOD_STATE_IDLE;
			end
			iod_pkg::IOD_STATE_IDLE: begin
				if (read_pend) begin
					next_op_done = 1'b1;
					next_op_rdata = RESERVED_MAP[hold_daddr] ? 8'h00 : cur_rdata;
					if (op_code == iod_pkg::IOD_OP_SKIP_ONE) begin
						next_skip_next = cur_rdata[hold_bit];
					end else if (op_code == iod_pkg::IOD_OP_SKIP_ZERO) begin
						next_skip_next = ~cur_rdata[hold_bit];
					end
				end else if (op_valid) begin
					next_hold_daddr = daddr;
					next_hold_bit = op_bit;
					case (op_code)
						iod_pkg::IOD_OP_IDLE: next_op_done = 1'b1;
						iod_pkg::IOD_OP_SLEEP: begin
							next_op_done = 1'b1;
							next_sleep_req = 1'b1;
						end
						iod_pkg::IOD_OP_WDOG_CLR: begin
							next_op_done = 1'b1;
							next_watchdog_clear = 1'b1;
						end
						iod_pkg::IOD_OP_BREAK: next_debug_break = 1'b1;
						default: begin
							if (!legal) begin
								next_op_done = 1'b1;
								next_op_error = 1'b1;
							end else if (op_code == iod_pkg::IOD_OP_OUT ||
								op_code == iod_pkg::IOD_OP_DS_WRITE) begin
								next_op_done = 1'b1;
								mem_we = !rsvd;
								// Flag registers: a one clears, a zero
								mem_wdata = W1C_MAP[daddr] ? 8'h00 : op_wdata;
								if (W1C_MAP[daddr]) begin
									next_state = iod_pkg::IOD_STATE_RMW;
									next_hold_bit = 3'h0;
									next_op_done = 1'b0;
									mem_we = 1'b0;
								end
							end else if (op_code == iod_pkg::IOD_OP_BIT_SET ||
								op_code == iod_pkg::IOD_OP_BIT_CLR) begin
								next_hold_set = (op_code == iod_pkg::IOD_OP_BIT_SET);
								next_state = rsvd ? iod_pkg::IOD_STATE_IDLE : iod_pkg::IOD_STATE_RMW;
								next_op_done = rsvd;
							end else begin
								next_read_pend = 1'b1;
							end
						end
					endcase
				end
			end
			default: next_state = iod_pkg::IOD_STATE_IDLE;
		endcase
	end

	// Plain writes to flag registers reuse the RMW slot with the write data
	logic [7:0] w1c_data, next_w1c_data;
	logic w1c_plain, next_w1c_plain;
	always_comb begin
		next_w1c_data = w1c_data;
		next_w1c_plain = 1'b0;
		if (state == iod_pkg::IOD_STATE_IDLE && next_state == iod_pkg::IOD_STATE_RMW) begin
			next_w1c_data = op_wdata;
			next_w1c_plain = (op_code == iod_pkg::IOD_OP_OUT || op_code == iod_pkg::IOD_OP_DS_WRITE);
		end
	end

	always_comb begin
		final_we = mem_we;
		final_wdata = (state == iod_pkg::IOD_STATE_RMW && w1c_plain) ?
			8'(cur_rdata & ~w1c_data) : mem_wdata;
		// A hardware flag set in the clearing cycle wins over the clear
		if (final_we && mem_waddr == flag_daddr) begin
			final_wdata = final_wdata | flag_set;
		end
		// Event bits collect every cycle, not only when the register is written
		next_flag_reg = flag_reg | flag_set;
		if (final_we && mem_waddr == flag_daddr) begin
			next_flag_reg = final_wdata;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state <= iod_pkg::IOD_STATE_IDLE;
			hold_daddr <= 8'h00;
			hold_set <= 1'b0;
			hold_bit <= 3'h0;
			read_pend <= 1'b0;
			op_done <= 1'b0;
			op_error <= 1'b0;
			op_rdata <= 8'h00;
			skip_next <= 1'b0;
			sleep_req <= 1'b0;
			watchdog_clear <= 1'b0;
			debug_break <= 1'b0;
			w1c_data <= 8'h00;
			w1c_plain <= 1'b0;
			flag_reg <= 8'h00;
		end else begin
			state <= next_state;
			hold_daddr <= next_hold_daddr;
			hold_set <= next_hold_set;
			hold_bit <= next_hold_bit;
			read_pend <= next_read_pend;
			op_done <= next_op_done;
			op_error <= next_op_error;
			op_rdata <= next_op_rdata;
			skip_next <= next_skip_next;
			sleep_req <= next_sleep_req;
			watchdog_clear <= next_watchdog_clear;
			debug_break <= next_debug_break;
			w1c_data <= next_w1c_data;
			w1c_plain <= next_w1c_plain;
			flag_reg <= next_flag_reg;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_ctrl_req;
		state == iod_pkg::IOD_STATE_IDLE && !read_pend && op_valid &&
			(op_code == iod_pkg::IOD_OP_IDLE || op_code == iod_pkg::IOD_OP_SLEEP ||
			op_code == iod_pkg::IOD_OP_WDOG_CLR);
	endsequence
	AST_CTRL_ONE_CYCLE: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_ctrl_req |=> op_done && !op_error) else $error("control op not done in one cycle");
	AST_BIT_RANGE: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state == iod_pkg::IOD_STATE_IDLE && !read_pend && op_valid && op_addr > 8'h1f &&
		(op_code == iod_pkg::IOD_OP_BIT_SET || op_code == iod_pkg::IOD_OP_BIT_CLR))
		|=> op_error && state == iod_pkg::IOD_STATE_IDLE)
		else $error("bit op above 0x1f accepted");
	AST_SHORT_RANGE: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state == iod_pkg::IOD_STATE_IDLE && !read_pend && op_valid && op_addr >= 8'h40 &&
		(op_code == iod_pkg::IOD_OP_IN || op_code == iod_pkg::IOD_OP_OUT))
		|=> op_error) else $error("short I/O op beyond 64 locations");
	AST_EXT_ONLY_DS: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state == iod_pkg::IOD_STATE_IDLE && !read_pend && op_valid && op_addr >= 8'h60 &&
		op_code == iod_pkg::IOD_OP_DS_READ) |=> !op_error ##1 op_done)
		else $error("data-space read of extended space refused");
	AST_OFFSET: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state == iod_pkg::IOD_STATE_IDLE && !read_pend && op_valid &&
		op_code == iod_pkg::IOD_OP_IN) |-> daddr == 8'(op_addr + 8'h20))
		else $error("data address not I/O address plus 0x20");
	AST_RMW_DONE: assert property (@(posedge ref_clk) disable iff (!resetn)
		state == iod_pkg::IOD_STATE_RMW |-> mem_we ##1 (op_done && state == iod_pkg::IOD_STATE_IDLE))
		else $error("read-modify-write did not finish");
	AST_SKIP_ONE: assert property (@(posedge ref_clk) disable iff (!resetn)
		(read_pend && op_code == iod_pkg::IOD_OP_SKIP_ONE && cur_rdata[hold_bit] &&
		!RESERVED_MAP[hold_daddr]) |=> skip_next) else $error("skip on one missed");
	AST_RSVD_READ: assert property (@(posedge ref_clk) disable iff (!resetn)
		(read_pend && RESERVED_MAP[hold_daddr]) |=> op_rdata == 8'h00 && op_done)
		else $error("reserved read not zero");
	AST_W1C_ZERO_KEEPS: assert property (@(posedge ref_clk) disable iff (!resetn)
		(state == iod_pkg::IOD_STATE_RMW && w1c_plain) |-> (final_wdata & cur_rdata & ~w1c_data) ==
		(cur_rdata & ~w1c_data)) else $error("zero write altered a flag");
endmodule

// >>> test/iod_core_model.sv
// Core execute-stage model issuing one I/O request at a time
`timescale 1ns/1ps
module iod_core_model (
	input wire logic ref_clk,
	input wire logic op_done,
	input wire logic debug_break,
	output logic op_valid,
	output iod_pkg::iod_op_t op_code,
	output logic [7:0] op_addr,
	output logic [2:0] op_bit,
	output logic [7:0] op_wdata
);
	initial begin
		op_valid = 1'b0;
		op_code = iod_pkg::IOD_OP_NONE;
		op_addr = 8'h00;
		op_bit = 3'h0;
		op_wdata = 8'h00;
	end
	// Strobe one cycle, hold the code until the answer, then scramble the qualifiers
	task automatic issue(input iod_pkg::iod_op_t c, input logic [7:0] a, input logic [2:0] b,
		input logic [7:0] d, output int lat);
		lat = 1;
		@(negedge ref_clk);
		op_valid = 1'b1;
		op_code = c;
		op_addr = a;
		op_bit = b;
		op_wdata = d;
		@(negedge ref_clk);
		op_valid = 1'b0;
		while (op_done !== 1'b1 && debug_break !== 1'b1 && lat < 20) begin
			@(negedge ref_clk);
			lat++;
		end
		op_addr = ~a;
		op_bit = ~b;
		op_wdata = ~d;
	endtask
endmodule

// >>> test/io_space_access_decoder_tb.sv
// Self-checking bench for the I/O space decoder
`timescale 1ns/1ps
`include "iod_params.svh"
`define TB_CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin miscompares++; \
	$display("wrong value %s exp %h got %h", nm, ex, gt); end end
module io_space_access_decoder_tb;
	localparam logic [255:0] W1C = 256'h1 << 8'h35;
	localparam logic [255:0] RSV = (256'h1 << 8'h33) | (256'h1 << 8'ha0);
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic op_valid, op_done, op_error, skip_next, sleep_req, watchdog_clear, debug_break;
	iod_pkg::iod_op_t op_code;
	logic [7:0] op_addr, op_wdata, op_rdata;
	logic [2:0] op_bit;
	logic [7:0] flag_set = 8'h00;
	logic [7:0] flag_set_addr = `IOD_FLAG_REG_INDEX;
	logic [14:0] expq[$];
	logic [14:0] e;
	logic [7:0] a, d;
	int miscompares = 0;
	int n_tests = 0;
	int lat;
	always #4 ref_clk = ~ref_clk;
	iod_core_model core (.ref_clk(ref_clk), .op_done(op_done), .debug_break(debug_break),
		.op_valid(op_valid), .op_code(op_code), .op_addr(op_addr), .op_bit(op_bit),
		.op_wdata(op_wdata));
	iod_decoder #(.RESERVED_MAP(RSV), .W1C_MAP(W1C)) uut (.ref_clk(ref_clk), .resetn(resetn),
		.op_valid(op_valid), .op_code(op_code), .op_addr(op_addr), .op_bit(op_bit),
		.op_wdata(op_wdata), .flag_set(flag_set), .flag_set_addr(flag_set_addr),
		.op_done(op_done), .op_error(op_error), .op_rdata(op_rdata), .skip_next(skip_next),
		.sleep_req(sleep_req), .watchdog_clear(watchdog_clear), .debug_break(debug_break));
	// Answer watcher: st = {read, error, skip, sleep, watchdog, break}
	always @(negedge ref_clk) begin
		if (op_done === 1'b1 || debug_break === 1'b1) begin
			e = expq.size() > 0 ? expq.pop_front() : 15'h7fff;
			`TB_CHK("status", {~e[8], e[12:8]}, {op_done, op_error, skip_next, sleep_req,
				watchdog_clear, debug_break})
			if (e[13]) `TB_CHK("rdata", e[7:0], op_rdata)
		end
	end
	task automatic go(iod_pkg::iod_op_t c, logic [7:0] ad, logic [2:0] b, logic [7:0] wd,
		logic [5:0] st, logic [7:0] rd);
		expq.push_back({1'b0, st, rd});
		core.issue(c, ad, b, wd, lat);
	endtask
	task automatic pulse_flags(logic [7:0] v);
		@(negedge ref_clk);
		flag_set = v;
		@(negedge ref_clk);
		flag_set = 8'h00;
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		#100000;
		miscompares++;
		close_out();
	end
	initial begin
		void'($urandom(81414));
		repeat (6) @(posedge ref_clk);
		@(negedge ref_clk);
		resetn = 1'b1;
		`TB_CHK("idle outputs", 6'h00, {op_done, op_error, skip_next, sleep_req,
			watchdog_clear, debug_break})
		// Plain ports only, never reserved or flag locations
		for (int i = 0; i < 8; i++) begin
			a = $urandom_range(0, 11);
			d = $urandom();
			go(iod_pkg::IOD_OP_OUT, a, 3'h0, d, 6'h00, 8'h00);
			`TB_CHK("out latency", 1, lat)
			go(iod_pkg::IOD_OP_DS_READ, a + `IOD_DATA_OFFSET, 3'h0, 8'h00, 6'h20, d);
			go(iod_pkg::IOD_OP_IN, a, 3'h0, 8'h00, 6'h20, d);
		end
		go(iod_pkg::IOD_OP_DS_WRITE, `IOD_LOW_TOP, 3'h0, 8'ha5, 6'h00, 8'h00);
		go(iod_pkg::IOD_OP_IN, `IOD_SHORT_LIMIT, 3'h0, 8'h00, 6'h20, 8'ha5);
		$display("test short io done");
		go(iod_pkg::IOD_OP_OUT, 8'h05, 3'h0, 8'h5a, 6'h00, 8'h00);
		go(iod_pkg::IOD_OP_BIT_SET, 8'h05, 3'h0, 8'h00, 6'h00, 8'h00);
		go(iod_pkg::IOD_OP_BIT_CLR, 8'h05, 3'h6, 8'h00, 6'h00, 8'h00);
		go(iod_pkg::IOD_OP_IN, 8'h05, 3'h0, 8'h00, 6'h20, 8'h1b);
		go(iod_pkg::IOD_OP_SKIP_ONE, 8'h05, 3'h1, 8'h00, 6'h08, 8'h00);
		go(iod_pkg::IOD_OP_SKIP_ZERO, 8'h05, 3'h1, 8'h00, 6'h00, 8'h00);
		go(iod_pkg::IOD_OP_SKIP_ZERO, 8'h05, 3'h2, 8'h00, 6'h08, 8'h00);
		go(iod_pkg::IOD_OP_OUT, `IOD_BIT_LIMIT, 3'h0, 8'h00, 6'h00, 8'h00);
		go(iod_pkg::IOD_OP_BIT_SET, `IOD_BIT_LIMIT, 3'h7, 8'h00, 6'h00, 8'h00);
		go(iod_pkg::IOD_OP_SKIP_ONE, `IOD_BIT_LIMIT, 3'h7, 8'h00, 6'h08, 8'h00);
		// Out-of-range addresses for each addressed op except skip on zero
		go(iod_pkg::IOD_OP_BIT_SET, 8'h20, 3'h0, 8'h00, 6'h10, 8'h00);
		go(iod_pkg::IOD_OP_BIT_CLR, 8'h20, 3'h0, 8'h00, 6'h10, 8'h00);
		go(iod_pkg::IOD_OP_SKIP_ONE, 8'h20, 3'h0, 8'h00, 6'h10, 8'h00);
		go(iod_pkg::IOD_OP_IN, 8'h40, 3'h0, 8'h00, 6'h10, 8'h00);
		go(iod_pkg::IOD_OP_OUT, `IOD_EXT_BASE, 3'h0, 8'h00, 6'h10, 8'h00);
		go(iod_pkg::IOD_OP_DS_READ, 8'h1f, 3'h0, 8'h00, 6'h10, 8'h00);
		go(iod_pkg::IOD_OP_DS_WRITE, 8'h1f, 3'h0, 8'h00, 6'h10, 8'h00);
		$display("test bit ops done");
		for (int i = 0; i < 3; i++) begin
			a = i == 0 ? `IOD_EXT_BASE : (i == 1 ? 8'hc0 : 8'hff);
			d = $urandom();
			go(iod_pkg::IOD_OP_DS_WRITE, a, 3'h0, d, 6'h00, 8'h00);
			go(iod_pkg::IOD_OP_DS_READ, a, 3'h0, 8'h00, 6'h20, d);
		end
		go(iod_pkg::IOD_OP_DS_WRITE, 8'ha0, 3'h0, 8'hff, 6'h00, 8'h00);
		go(iod_pkg::IOD_OP_DS_READ, 8'ha0, 3'h0, 8'h00, 6'h20, 8'h00);
		go(iod_pkg::IOD_OP_OUT, 8'h13, 3'h0, 8'hff, 6'h00, 8'h00);
		go(iod_pkg::IOD_OP_IN, 8'h13, 3'h0, 8'h00, 6'h20, 8'h00);
		$display("test extended and reserved done");
		go(iod_pkg::IOD_OP_OUT, `IOD_FLAG_REG_INDEX, 3'h0, 8'hff, 6'h00, 8'h00);
		pulse_flags(8'h05);
		go(iod_pkg::IOD_OP_IN, `IOD_FLAG_REG_INDEX, 3'h0, 8'h00, 6'h20, 8'h05);
		go(iod_pkg::IOD_OP_OUT, `IOD_FLAG_REG_INDEX, 3'h0, 8'h01, 6'h00, 8'h00);
		go(iod_pkg::IOD_OP_IN, `IOD_FLAG_REG_INDEX, 3'h0, 8'h00, 6'h20, 8'h04);
		pulse_flags(8'h01);
		go(iod_pkg::IOD_OP_BIT_SET, `IOD_FLAG_REG_INDEX, 3'h4, 8'h00, 6'h00, 8'h00);
		go(iod_pkg::IOD_OP_IN, `IOD_FLAG_REG_INDEX, 3'h0, 8'h00, 6'h20, 8'h00);
		$display("test flag clearing done");
		pulse_flags(8'h02);
		go(iod_pkg::IOD_OP_IDLE, 8'h00, 3'h0, 8'h00, 6'h00, 8'h00);
		`TB_CHK("idle latency", `IOD_CTRL_CYCLES, lat)
		go(iod_pkg::IOD_OP_SLEEP, 8'h00, 3'h0, 8'h00, 6'h04, 8'h00);
		`TB_CHK("sleep latency", `IOD_CTRL_CYCLES, lat)
		go(iod_pkg::IOD_OP_WDOG_CLR, 8'h00, 3'h0, 8'h00, 6'h02, 8'h00);
		`TB_CHK("watchdog latency", `IOD_CTRL_CYCLES, lat)
		go(iod_pkg::IOD_OP_BREAK, 8'h00, 3'h0, 8'h00, 6'h01, 8'h00);
		go(iod_pkg::IOD_OP_IN, `IOD_FLAG_REG_INDEX, 3'h0, 8'h00, 6'h20, 8'h02);
		$display("test control ops done");
		repeat (3) @(negedge ref_clk);
		`TB_CHK("answers left", 0, expq.size())
		close_out();
	end
endmodule
